/* File: bench/rhp_device_model.sv */
`timescale 1ns/1ps
module rhp_device_model
#(
	parameter int recover_cycles = 20
)
(
	// Clock and supply.
	input wire logic clock,
	input wire logic supply_good,
	// Host pins.
	input wire logic reg_select_n,
	input wire logic ext_ram_select_n,
	input wire logic bank_sel,
	input wire logic store_strobe_n,
	input wire logic output_gate_n,
	input wire logic [3:0] reg_index,
	input wire logic [7:0] data_lines_out,
	// Answers.
	output logic [7:0] data_lines_in,
	output logic dev_reset_n,
	output logic dev_battery
);
	logic [7:0] regs [16];
	logic [7:0] bank [2][16];
	logic [7:0] last = 8'h00;
	int hold = 0;
	// Bank selects are blocked until the supply is back and settled.
	wire logic bank0_ram_select_n = ext_ram_select_n | bank_sel |
		!dev_reset_n;
	wire logic bank1_ram_select_n = ext_ram_select_n | !bank_sel |
		!dev_reset_n;
	wire logic hit = !reg_select_n | !bank0_ram_select_n |
		!bank1_ram_select_n;
	wire logic rd_on = store_strobe_n & !output_gate_n & dev_reset_n &
		hit;
	wire logic wr_on = !store_strobe_n & dev_reset_n &
		hit;
	// Reset stays active for the recovery time after the supply returns.
	assign dev_reset_n = supply_good && hold == 0;
	assign dev_battery = !supply_good;
	// A floating bus shows a changing pattern, never the last value.
	assign data_lines_in = !rd_on ? ~last :
		!reg_select_n ? regs[reg_index] :
		bank[bank_sel][reg_index];
	// Stores keep the last value seen before the write ends.
	always @(posedge clock)
	begin
		last <= data_lines_in;
		hold <= !supply_good ? recover_cycles : hold > 0 ? hold - 1 : 0;
		if (wr_on && !reg_select_n)
			regs[reg_index] <= data_lines_out;
		if (wr_on && reg_select_n)
			bank[bank_sel][reg_index] <= data_lines_out;
	end
endmodule

/* File: bench/rhp_host_port_bank_select_bench.sv */
`timescale 1ns/1ps
module rhp_host_port_bank_select_bench;
	import rhp_pkg::*;
	logic clock, rst_b, req, req_write, supply_good, busy, done, refused;
	rhp_target_type req_target;
	logic [3:0] req_index, reg_index;
	logic [7:0] req_wdata, rdata, d_in, d_out;
	logic rs_n, ex_n, bsel, st_n, og_n, oe, rst_dev_n, batt;
	int n_mismatch = 0;
	int n_compared = 0;
	logic seen_refused;
	rhp_host #(.cycles_strobe(3), .cycles_access(3)) rhp_host_i (
		.clock(clock), .rst_b(rst_b), .req(req), .req_write(req_write),
		.req_target(req_target), .req_index(req_index),
		.req_wdata(req_wdata), .busy(busy), .done(done),
		.refused(refused), .rdata(rdata), .dev_reset_n(rst_dev_n),
		.dev_battery(batt), .reg_select_n(rs_n), .ext_ram_select_n(ex_n),
		.bank_sel(bsel), .store_strobe_n(st_n), .output_gate_n(og_n),
		.reg_index(reg_index), .data_lines_in(d_in),
		.data_lines_out(d_out), .data_lines_oe(oe));
	rhp_device_model rhp_device_model_i (
		.clock(clock), .supply_good(supply_good), .reg_select_n(rs_n),
		.ext_ram_select_n(ex_n), .bank_sel(bsel), .store_strobe_n(st_n),
		.output_gate_n(og_n), .reg_index(reg_index),
		.data_lines_out(d_out), .data_lines_in(d_in),
		.dev_reset_n(rst_dev_n), .dev_battery(batt));
	// Free-running clock.
	initial
	begin
		clock = 0;
		forever #2 clock = ~clock;
	end
	task automatic conclude();
		$display("compared %0d mismatched %0d", n_compared, n_mismatch);
		if (n_mismatch == 0 && n_compared > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	task automatic check(input logic [7:0] seen,
		input logic [7:0] exp);
		n_compared++;
		if (seen !== exp)
		begin
			n_mismatch++;
			$display("wrong value at %0t: %h expected %h", $time, seen, exp);
		end
	endtask
	// One request, then a bounded wait for done or refused.
	task automatic access(input logic w, input rhp_target_type t,
		input logic [3:0] i, input logic [7:0] d);
		int k;
		req = 1;
		req_write = w;
		req_target = t;
		req_index = i;
		req_wdata = d;
		@(negedge clock);
		req = 0;
		for (k = 0; k < 200 && !done && !refused; k++)
			@(negedge clock);
		seen_refused = refused;
		if (k == 200)
		begin
			n_mismatch++;
			conclude();
		end
		@(negedge clock);
	endtask
	task automatic test_regs();
		access(1, rhp_tgt_reg, 4'h0, 8'h3c);
		check({7'h00, seen_refused}, 8'h00);
		access(1, rhp_tgt_reg, 4'hf, 8'hc3);
		access(0, rhp_tgt_reg, 4'h0, 8'h00);
		check(rdata, 8'h3c);
		access(0, rhp_tgt_reg, 4'hf, 8'h00);
		check(rdata, 8'hc3);
		$display("registers done");
	endtask
	task automatic test_banks();
		access(1, rhp_tgt_bank0, 4'h3, 8'ha5);
		access(1, rhp_tgt_bank1, 4'h3, 8'h5a);
		access(0, rhp_tgt_bank0, 4'h3, 8'h00);
		check(rdata, 8'ha5);
		access(0, rhp_tgt_bank1, 4'h3, 8'h00);
		check(rdata, 8'h5a);
		$display("banks done");
	endtask
	// Pin order of one bank write, watched edge by edge, then read back.
	task automatic test_pins();
		int k;
		req = 1;
		req_write = 1;
		req_target = rhp_tgt_bank1;
		req_index = 4'h5;
		req_wdata = 8'h77;
		@(negedge clock);
		req = 0;
		check({5'h00, bsel, rs_n, ex_n}, 8'h06);
		check({4'h0, reg_index}, 8'h05);
		check({7'h00, busy}, 8'h01);
		@(negedge clock);
		check(d_out, 8'h77);
		check({6'h00, oe, og_n}, 8'h03);
		@(negedge clock);
		check({6'h00, st_n, og_n}, 8'h01);
		for (k = 0; k < 200 && !done; k++)
			@(negedge clock);
		if (k == 200)
		begin
			n_mismatch++;
			conclude();
		end
		check({6'h00, st_n, rs_n & ex_n}, 8'h03);
		@(negedge clock);
		check({7'h00, done}, 8'h00);
		access(0, rhp_tgt_bank1, 4'h5, 8'h00);
		check(rdata, 8'h77);
		$display("pins done");
	endtask
	task automatic test_power();
		int k;
		supply_good = 0;
		repeat (2) @(negedge clock);
		access(1, rhp_tgt_reg, 4'h0, 8'h11);
		check({7'h00, seen_refused}, 8'h01);
		check({7'h00, rs_n & st_n}, 8'h01);
		supply_good = 1;
		for (k = 0; k < 50 && !rst_dev_n; k++)
			@(negedge clock);
		if (k == 50)
		begin
			n_mismatch++;
			conclude();
		end
		access(0, rhp_tgt_reg, 4'h0, 8'h00);
		check({7'h00, seen_refused}, 8'h00);
		check(rdata, 8'h3c);
		$display("power done");
	endtask
	// Main sequence.
	initial
	begin
		rst_b = 1'b0;
		req = 1'b0;
		req_write = 1'b0;
		req_index = 4'h0;
		req_wdata = 8'h00;
		req_target = rhp_tgt_reg;
		supply_good = 1;
		repeat (5) @(negedge clock);
		rst_b = 1;
		test_regs();
		test_banks();
		test_pins();
		test_power();
		conclude();
	end
endmodule

/* File: logic/rhp_defs.svh */
`ifndef RHP_DEFS_SVH
`define RHP_DEFS_SVH

// Device register window.
`define RHP_REG_COUNT 16
`define RHP_INDEX_W 4
`define RHP_DATA_W 8

// Host-side phase lengths in cycles of the 4 ns clock.
`define RHP_CLK_PERIOD_NS 4
`define RHP_SETUP_NS 8
`define RHP_STROBE_NS 72
`define RHP_ACCESS_NS 88
`define RHP_RECOVER_NS 12
`define RHP_SETUP_CYC \
	((`RHP_SETUP_NS + `RHP_CLK_PERIOD_NS - 1) / `RHP_CLK_PERIOD_NS)
`define RHP_STROBE_CYC \
	((`RHP_STROBE_NS + `RHP_CLK_PERIOD_NS - 1) / `RHP_CLK_PERIOD_NS)
`define RHP_ACCESS_CYC \
	((`RHP_ACCESS_NS + `RHP_CLK_PERIOD_NS - 1) / `RHP_CLK_PERIOD_NS)
`define RHP_RECOVER_CYC \
	((`RHP_RECOVER_NS + `RHP_CLK_PERIOD_NS - 1) / `RHP_CLK_PERIOD_NS)
`endif

/* File: logic/rhp_host.sv */
`timescale 1ns/1ps
`include "rhp_defs.svh"
module rhp_host
#(
	parameter int cycles_strobe = `RHP_STROBE_CYC,
	parameter int cycles_access = `RHP_ACCESS_CYC
)
(
	// Clock and reset.
	input wire logic clock,
	input wire logic rst_b,
	// User command port.
	input wire logic req,
	input wire logic req_write,
	input wire rhp_pkg::rhp_target_type req_target,
	input wire logic [`RHP_INDEX_W-1:0] req_index,
	input wire logic [`RHP_DATA_W-1:0] req_wdata,
	output logic busy,
	output logic done,
	output logic refused,
	output logic [`RHP_DATA_W-1:0] rdata,
	// Supply state, seen as device reset and battery levels.
	input wire logic dev_reset_n,
	input wire logic dev_battery,
	// Device pins.
	output logic reg_select_n,
	output logic ext_ram_select_n,
	output logic bank_sel,
	output logic store_strobe_n,
	output logic output_gate_n,
	output logic [`RHP_INDEX_W-1:0] reg_index,
	input wire logic [`RHP_DATA_W-1:0] data_lines_in,
	output logic [`RHP_DATA_W-1:0] data_lines_out,
	output logic data_lines_oe
);
	import rhp_pkg::*;

	rhp_state_type state;
	logic [7:0] count;
	logic wr;
	logic path_ok;
	// Bound on an access from accept to the done pulse, in clock cycles; counts both strobe and access phases.
	localparam int access_span = `RHP_SETUP_CYC + cycles_access +
		cycles_strobe + `RHP_RECOVER_CYC;

	// The device is usable only while its reset is released and no battery.
	assign path_ok = dev_reset_n && !dev_battery;

	// Sequencer: setup, strobe, recovery; one access at a time.
	always_ff @(posedge clock or negedge rst_b)
	begin
		if (!rst_b)
		begin
			state <= rhp_idle;
			count <= 8'h00;
			wr <= 1'b0;
		end
		else
		begin
			case (state)
				rhp_idle:
					if (req && path_ok)
					begin
						state <= rhp_setup;
						wr <= req_write;
						count <= 8'(`RHP_SETUP_CYC);
					end
				rhp_setup:
					if (count <= 8'h01)
					begin
						state <= rhp_strobe;
						count <= wr ? 8'(cycles_strobe) : 8'(cycles_access);
					end
					else
						count <= count - 8'h01;
				rhp_strobe:
					if (count <= 8'h01)
					begin
						state <= rhp_recover;
						count <= 8'(`RHP_RECOVER_CYC);
					end
					else
						count <= count - 8'h01;
				rhp_recover:
					if (count <= 8'h01)
						state <= rhp_done;
					else
						count <= count - 8'h01;
				rhp_done:
					state <= rhp_idle;
				default:
					state <= rhp_idle;
			endcase
		end
	end

	// The handshake ends in a bounded time with a one-cycle done pulse.
	a_access_bound: assert property (
		@(posedge clock) disable iff (!rst_b)
		$rose(busy) |-> ##[1:access_span] done)
		else $error("access did not finish in time");
	a_done_pulse: assert property (
		@(posedge clock) disable iff (!rst_b)
		done |=> !done && store_strobe_n && output_gate_n)
		else $error("done not single cycle with strobes idle");

	// Pin drive; index held steady for the whole access, selects released one cycle into recovery, after the strobe or gate rises.
	always_ff @(posedge clock or negedge rst_b)
	begin
		if (!rst_b)
		begin
			reg_select_n <= 1'b1;
			ext_ram_select_n <= 1'b1;
			bank_sel <= 1'b0;
			store_strobe_n <= 1'b1;
			output_gate_n <= 1'b1;
			reg_index <= 4'h0;
			data_lines_out <= 8'h00;
			data_lines_oe <= 1'b0;
		end
		else
		begin
			if (state == rhp_idle && req && path_ok)
			begin
				reg_index <= req_index;
				data_lines_out <= req_wdata;
				bank_sel <= (req_target == rhp_tgt_bank1);
				// Only one of the two selects is ever lowered.
				reg_select_n <= (req_target != rhp_tgt_reg);
				ext_ram_select_n <= (req_target == rhp_tgt_reg);
			end
			else if (state == rhp_recover || state == rhp_done)
			begin
				reg_select_n <= 1'b1;
				ext_ram_select_n <= 1'b1;
			end
			// Strobe falls after setup so index is stable first.
			store_strobe_n <= !(state == rhp_setup && count <= 8'h01 && wr) &&
				!(state == rhp_strobe && wr && count > 8'h01);
			// Gate stays high during writes to avoid contention.
			output_gate_n <= !(state == rhp_setup && count <= 8'h01 && !wr) &&
				!(state == rhp_strobe && !wr && count > 8'h01);
			data_lines_oe <= wr && (state == rhp_setup || state == rhp_strobe);
		end
	end

	// Only one select at a time, index steady while any strobe is low.
	a_sel_exclusive: assert property (
		@(posedge clock) disable iff (!rst_b)
		!(!reg_select_n && !ext_ram_select_n))
		else $error("both selects low");
	a_index_hold: assert property (
		@(posedge clock) disable iff (!rst_b)
		(!store_strobe_n || !output_gate_n) |=> $stable(reg_index))
		else $error("index changed during access");
	a_bank_map: assert property (
		@(posedge clock) disable iff (!rst_b)
		(state == rhp_idle && req && path_ok && req_target == rhp_tgt_bank1)
		|=> bank_sel && reg_select_n && !ext_ram_select_n)
		else $error("bank mapping wrong");

	// Strobe edges fall inside the select window, data around them.
	a_strobe_setup: assert property (
		@(posedge clock) disable iff (!rst_b)
		$fell(store_strobe_n) |->
		!$past(reg_select_n) || !$past(ext_ram_select_n))
		else $error("strobe fell before a select");
	a_strobe_rise: assert property (
		@(posedge clock) disable iff (!rst_b)
		$rose(store_strobe_n) |-> !reg_select_n || !ext_ram_select_n)
		else $error("select left before strobe");
	a_oe_strobe: assert property (
		@(posedge clock) disable iff (!rst_b)
		!store_strobe_n |-> data_lines_oe)
		else $error("strobe low without write data");
	a_oe_release: assert property (
		@(posedge clock) disable iff (!rst_b)
		$rose(store_strobe_n) |-> data_lines_oe)
		else $error("write data dropped before strobe rose");

	// Reads use the gate alone; the gate stays high while data is driven.
	a_gate_write: assert property (
		@(posedge clock) disable iff (!rst_b)
		!(data_lines_oe && !output_gate_n))
		else $error("output gate low while host drives data");
	a_gate_setup: assert property (
		@(posedge clock) disable iff (!rst_b)
		$fell(output_gate_n) |->
		!$past(reg_select_n) || !$past(ext_ram_select_n))
		else $error("gate fell before a select");
	a_read_strobe: assert property (
		@(posedge clock) disable iff (!rst_b)
		(state == rhp_strobe && !wr) |-> store_strobe_n)
		else $error("strobe low during a read");

	// Read capture at end of access, and user handshake.
	always_ff @(posedge clock or negedge rst_b)
	begin
		if (!rst_b)
		begin
			rdata <= 8'h00;
			busy <= 1'b0;
			done <= 1'b0;
			refused <= 1'b0;
		end
		else
		begin
			if (state == rhp_strobe && !wr && count == 8'h01)
				rdata <= data_lines_in;
			busy <= (state != rhp_idle && state != rhp_done) ||
				(state == rhp_idle && req && path_ok);
			done <= (state == rhp_recover && count <= 8'h01);
			refused <= (state == rhp_idle && req && !path_ok);
		end
	end

	// A refused request leaves every pin idle and the sequencer at rest.
	a_no_fail_go: assert property (
		@(posedge clock) disable iff (!rst_b)
		(state == rhp_idle && req && !path_ok) |=> refused && !busy)
		else $error("access started while supply bad");
	a_refuse_quiet: assert property (
		@(posedge clock) disable iff (!rst_b)
		refused |-> reg_select_n && ext_ram_select_n && store_strobe_n &&
		output_gate_n)
		else $error("pins moved on a refused request");
endmodule

/* File: logic/rhp_pkg.sv */
package rhp_pkg;
	typedef enum logic [4:0] {
		rhp_idle = 5'h01,
		rhp_setup = 5'h02,
		rhp_strobe = 5'h04,
		rhp_recover = 5'h08,
		rhp_done = 5'h10
	} rhp_state_type;
	typedef enum logic [1:0] {
		rhp_tgt_reg = 2'h0,
		rhp_tgt_bank0 = 2'h1,
		rhp_tgt_bank1 = 2'h2
	} rhp_target_type;
endpackage
